// ### logic/gdi_pkg.sv
/*
 * gdi_pkg: constants, register map and carrier types of the instrument-side
 * parallel bus port. Assumes an AXI4-Lite register master and a bus
 * transceiver that turns the open-drain lines into levels and strobes.
 */
`default_nettype none
package gdi_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_MASK = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;
	localparam logic [7:0] OFS_COND = 8'h10;
	localparam logic [7:0] OFS_ERR = 8'h14;
	localparam logic [7:0] OFS_DATA = 8'h18;

	// control register bits
	localparam int CTRL_ENH = 0;
	localparam int CTRL_SWEEP_RESET = 1;
	localparam int CTRL_LOCAL_KEY = 2;
	localparam int CTRL_MEM_CLEAR = 3;

	// condition register bits 0..3 are event sources
	localparam int COND_SWEEP = 4;
	localparam int COND_BUSY = 5;

	// status byte layout
	localparam int SB_SWEEP = 5;
	localparam int SB_RQS = 6;
	localparam int SB_BUSY = 7;

	// state word bits above the status byte, then the data register valid bit
	localparam int ST_BOOTED = 8;
	localparam int ST_LONLY = 9;
	localparam int ST_LISTEN = 10;
	localparam int ST_TALK = 11;
	localparam int ST_REMOTE = 12;
	localparam int ST_LOCKOUT = 13;
	localparam int ST_ARMED = 14;
	localparam int ST_SPOLL = 15;
	localparam int DATA_VALID = 8;

	// addressing
	localparam logic [4:0] ADDR_DEFAULT = 5'h11;
	localparam logic [4:0] ADDR_LISTEN_ONLY = 5'h1F;
	localparam logic [7:0] ADDR_MAX = 8'h1F;
	localparam logic [7:0] ERR_RANGE = 8'h64;

	// command byte groups and universal/addressed commands
	localparam logic [1:0] GRP_LISTEN = 2'h1;
	localparam logic [1:0] GRP_TALK = 2'h2;
	localparam logic [6:0] CMD_GTL = 7'h01;
	localparam logic [6:0] CMD_SDC = 7'h04;
	localparam logic [6:0] CMD_GET = 7'h08;
	localparam logic [6:0] CMD_LLO = 7'h11;
	localparam logic [6:0] CMD_DCL = 7'h14;
	localparam logic [6:0] CMD_SPE = 7'h18;
	localparam logic [6:0] CMD_SPD = 7'h19;
	localparam logic [6:0] CMD_UNL = 7'h3F;
	localparam logic [6:0] CMD_UNT = 7'h5F;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic atn;
		logic ifc;
		logic ren;
		logic eoi;
		logic byte_stb;
		logic talk_ack;
		logic [7:0] data;
	} gdi_bus_in_t;

	typedef struct packed {
		logic [7:0] dio;
		logic dio_oe;
		logic srq_o;
		logic srq_oe;
	} gdi_bus_out_t;

	typedef struct packed {
		logic remote_led;
		logic srq_led;
		logic lockout;
		logic listen_only;
		logic preset;
		logic sweep_start;
	} gdi_inst_t;
endpackage : gdi_pkg
`default_nettype wire

// ### logic/gdi_core.sv
/*
 * gdi_core: instrument-side bus port. Addressing, command decode,
 * remote/local/lockout, serial poll, service request, trigger, and an
 * AXI4-Lite register slave. Assumes bus lines arrive synchronous to aclk,
 * byte_stb pulses once per accepted byte and talk_ack once per byte the
 * controller takes from us; nonvolatile address storage sits outside.
 */
// Notes on behaviour
// - bus address 0..31 accepted, kept in nonvolatile storage.
// - address 31 means listen-only, never addressed to talk or listen.
// - address write above 31 refused, old kept, error code 100 reported.
// - memory clear restores address 17.
// - bytes with ATN true are commands, with ATN false are data.
// - IFC drops talker and listener state.
// - DCL, or SDC while listening, flushes input, clears error, presets.
// - REN false leaves lockout and returns to local.
// - GTL while listening returns to local unless locked out.
// - LLO disables the local key.
// - parallel poll and pass control ignored, no data line driven.
// - remote lights indicator; local key works only without lockout.
// - serial poll of our talk address puts status byte on data lines.
// - service request pulls SRQ low, sets bit 6, lights indicator.
// - SRQ released when the controller serially polls us.
// - only status bits 0..3 can request service, each masked.
// - GET while listening starts sweep if enhanced and sweep reset.
// - event bits set on false-to-true edge of their condition.
// - new event with nonzero status AND mask sets bit 6 and SRQ.
// - writable status mask selects service request sources.
// - address bytes carry address low five bits, talk/listen bits above.
// - sweep and busy bits are live, never request service; bit 4 zero.
`timescale 1ns/1ps
`default_nettype none
module gdi_core (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// parallel bus
	input wire gdi_pkg::gdi_bus_in_t bus_in,
	output gdi_pkg::gdi_bus_out_t bus_out,
	// nonvolatile address storage
	input wire logic [4:0] nv_addr_rd,
	output logic nv_addr_we,
	output logic [4:0] nv_addr_wr,
	// instrument side
	output gdi_pkg::gdi_inst_t inst
);
	// AXI capture state
	logic aw_got;
	logic w_got;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic w_lane0;

	// block state
	logic booted;
	logic [4:0] my_addr;
	logic listener;
	logic talker;
	logic spoll;
	logic remote;
	logic lockout;
	logic enh;
	logic armed;
	logic [3:0] mask;
	logic [5:0] cond;
	logic [3:0] cond_prev;
	logic [3:0] events;
	logic rqs;
	logic [7:0] err_code;
	logic [7:0] rx_byte;
	logic rx_valid;

	function automatic logic is_mine(input logic [6:0] b, input logic [1:0] g,
			input logic [4:0] a);
		is_mine = (b[6:5] == g) && (b[4:0] == a);
	endfunction : is_mine

	// write fires once both halves are in
	logic wr_fire;
	logic wr_ok;
	logic rd_fire;
	assign wr_fire = aw_got & w_got & ~s_axi_bvalid;
	assign wr_ok = wr_fire & w_lane0;
	assign rd_fire = s_axi_arvalid & s_axi_arready;

	function automatic logic wr_hit(input logic ok, input logic [7:0] a,
			input logic [7:0] ofs);
		wr_hit = ok && (a == ofs);
	endfunction : wr_hit

	function automatic logic mapped(input logic [7:0] a);
		mapped = a == gdi_pkg::OFS_CTRL || a == gdi_pkg::OFS_ADDR
			|| a == gdi_pkg::OFS_MASK || a == gdi_pkg::OFS_STAT
			|| a == gdi_pkg::OFS_COND || a == gdi_pkg::OFS_ERR
			|| a == gdi_pkg::OFS_DATA;
	endfunction : mapped

	logic w_ctrl;
	logic w_addr;
	logic w_memclr;
	logic addr_bad;
	assign w_ctrl = wr_hit(wr_ok, aw_addr, gdi_pkg::OFS_CTRL);
	assign w_addr = wr_hit(wr_ok, aw_addr, gdi_pkg::OFS_ADDR);
	assign w_memclr = w_ctrl & w_data[gdi_pkg::CTRL_MEM_CLEAR];
	// whole word compared so high garbage cannot alias a legal address
	assign addr_bad = w_addr & (w_data > {24'h00_0000, gdi_pkg::ADDR_MAX});

	// bus byte classification
	logic lonly;
	logic cmd_stb;
	logic dat_stb;
	logic [6:0] cb;
	logic clr_dev;
	logic poll_done;
	logic trig;
	assign lonly = my_addr == gdi_pkg::ADDR_LISTEN_ONLY;
	assign cmd_stb = booted & bus_in.byte_stb & bus_in.atn;
	assign dat_stb = bus_in.byte_stb & ~bus_in.atn & listener;
	assign cb = bus_in.data[6:0];
	assign clr_dev = cmd_stb & ((cb == gdi_pkg::CMD_DCL)
		| (cb == gdi_pkg::CMD_SDC & listener));
	assign poll_done = bus_in.talk_ack & talker & spoll & ~bus_in.atn;
	assign trig = cmd_stb & (cb == gdi_pkg::CMD_GET) & listener;

	// AXI write channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_lane0 <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= gdi_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata;
				w_lane0 <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(aw_addr) ? gdi_pkg::RESP_OKAY
					: gdi_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// status byte as the controller sees it
	logic [7:0] status;
	assign status = {cond[gdi_pkg::COND_BUSY], rqs,
		cond[gdi_pkg::COND_SWEEP], 1'b0, events};

	// AXI read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= gdi_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= mapped(s_axi_araddr) ? gdi_pkg::RESP_OKAY
				: gdi_pkg::RESP_SLVERR;
			s_axi_rdata <= 32'h0000_0000;
			unique case ({s_axi_araddr[7:2], 2'b00})
			gdi_pkg::OFS_CTRL: s_axi_rdata[gdi_pkg::CTRL_ENH] <= enh;
			gdi_pkg::OFS_ADDR: s_axi_rdata[4:0] <= my_addr;
			gdi_pkg::OFS_MASK: s_axi_rdata[3:0] <= mask;
			gdi_pkg::OFS_STAT: s_axi_rdata[15:0] <= {spoll, armed, lockout,
				remote, talker, listener, lonly, booted, status};
			gdi_pkg::OFS_COND: s_axi_rdata[5:0] <= cond;
			gdi_pkg::OFS_ERR: s_axi_rdata[7:0] <= err_code;
			gdi_pkg::OFS_DATA: s_axi_rdata[8:0] <= {rx_valid, rx_byte};
			default: s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// address: boot load, software write, memory clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			booted <= 1'b0;
			my_addr <= gdi_pkg::ADDR_DEFAULT;
			nv_addr_we <= 1'b0;
			nv_addr_wr <= gdi_pkg::ADDR_DEFAULT;
		end else begin
			nv_addr_we <= 1'b0;
			if (!booted) begin
				booted <= 1'b1;
				my_addr <= nv_addr_rd;
			end else if (w_memclr) begin
				my_addr <= gdi_pkg::ADDR_DEFAULT;
				nv_addr_we <= 1'b1;
				nv_addr_wr <= gdi_pkg::ADDR_DEFAULT;
			end else if (w_addr && !addr_bad) begin
				my_addr <= w_data[4:0];
				nv_addr_we <= 1'b1;
				nv_addr_wr <= w_data[4:0];
			end
		end
	end

	// error register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_code <= 8'h00;
		end else if (addr_bad) begin
			err_code <= gdi_pkg::ERR_RANGE;
		end else if (clr_dev) begin
			err_code <= 8'h00;
		end
	end

	// talker / listener / serial poll mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			listener <= 1'b0;
			talker <= 1'b0;
			spoll <= 1'b0;
		end else if (bus_in.ifc || lonly) begin
			listener <= lonly && booted;
			talker <= 1'b0;
			spoll <= 1'b0;
		end else if (cmd_stb) begin
			if (is_mine(cb, gdi_pkg::GRP_LISTEN, my_addr)) begin
				listener <= 1'b1;
				talker <= 1'b0;
			end else if (cb == gdi_pkg::CMD_UNL) begin
				listener <= 1'b0;
			end
			if (is_mine(cb, gdi_pkg::GRP_TALK, my_addr)) begin
				talker <= 1'b1;
				listener <= 1'b0;
			end else if (cb[6:5] == gdi_pkg::GRP_TALK || cb == gdi_pkg::CMD_UNT) begin
				talker <= 1'b0;
			end
			if (cb == gdi_pkg::CMD_SPE) begin
				spoll <= 1'b1;
			end else if (cb == gdi_pkg::CMD_SPD) begin
				spoll <= 1'b0;
			end
		end
	end

	// remote, local and lockout
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			remote <= 1'b0;
			lockout <= 1'b0;
		end else if (!bus_in.ren) begin
			remote <= 1'b0;
			lockout <= 1'b0;
		end else begin
			if (cmd_stb && is_mine(cb, gdi_pkg::GRP_LISTEN, my_addr) && !lonly) begin
				remote <= 1'b1;
			end else if (cmd_stb && cb == gdi_pkg::CMD_GTL && listener
					&& !lockout) begin
				remote <= 1'b0;
			end else if (w_ctrl && w_data[gdi_pkg::CTRL_LOCAL_KEY]
					&& !lockout) begin
				remote <= 1'b0;
			end
			if (cmd_stb && cb == gdi_pkg::CMD_LLO) begin
				lockout <= 1'b1;
			end
		end
	end

	// mode, mask, conditions, sweep arming
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enh <= 1'b0;
			mask <= 4'h0;
			cond <= 6'h00;
			armed <= 1'b0;
		end else begin
			if (w_ctrl) begin
				enh <= w_data[gdi_pkg::CTRL_ENH];
			end
			if (wr_hit(wr_ok, aw_addr, gdi_pkg::OFS_MASK)) begin
				mask <= w_data[3:0];
			end
			if (wr_hit(wr_ok, aw_addr, gdi_pkg::OFS_COND)) begin
				cond <= w_data[5:0];
			end
			if (trig && enh && armed) begin
				armed <= 1'b0;
			end else if (w_ctrl && w_data[gdi_pkg::CTRL_SWEEP_RESET]) begin
				armed <= 1'b1;
			end
		end
	end

	// event bits and require-service
	logic [3:0] rise;
	logic [3:0] next_events;
	always_comb begin
		rise = cond[3:0] & ~cond_prev;
		rise[0] = rise[0] | addr_bad;
		next_events = (poll_done ? 4'h0 : events) | rise;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cond_prev <= 4'h0;
			events <= 4'h0;
			rqs <= 1'b0;
		end else begin
			cond_prev <= cond[3:0];
			events <= next_events;
			if (rise != 4'h0 && (next_events & mask) != 4'h0) begin
				rqs <= 1'b1;
			end else if (poll_done || clr_dev) begin
				rqs <= 1'b0;
			end
		end
	end

	// received data byte
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_byte <= 8'h00;
			rx_valid <= 1'b0;
		end else if (dat_stb) begin
			rx_byte <= bus_in.data;
			rx_valid <= 1'b1;
		end else if (clr_dev) begin
			rx_valid <= 1'b0;
		end else if (rd_fire && {s_axi_araddr[7:2], 2'b00} == gdi_pkg::OFS_DATA) begin
			rx_valid <= 1'b0;
		end
	end

	// bus and instrument outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus_out <= '0;
			inst <= '0;
		end else begin
			// parallel poll and pass control never reach here
			bus_out.dio_oe <= talker & spoll & ~bus_in.atn;
			bus_out.dio <= status;
			bus_out.srq_o <= 1'b0;
			bus_out.srq_oe <= rqs;
			inst.srq_led <= rqs;
			inst.remote_led <= remote;
			inst.lockout <= lockout;
			inst.listen_only <= lonly;
			inst.preset <= clr_dev;
			inst.sweep_start <= trig & enh & armed;
		end
	end
endmodule : gdi_core
`default_nettype wire

// ### tb/gdi_core_properties.sv
/* gdi_core_properties: timing checks on the bus port of gdi_core.
   assumes: bound to gdi_core, one clock domain aclk. */
`timescale 1ns/1ps
`default_nettype none
module gdi_core_properties (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	// bus and instrument
	input wire gdi_pkg::gdi_bus_in_t bus_in,
	input wire gdi_pkg::gdi_bus_out_t bus_out,
	input wire gdi_pkg::gdi_inst_t inst
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_poll_ack;
		bus_in.talk_ack && bus_out.dio_oe;
	endsequence
	property p_b_answer;
		s_wr_both |-> ##2 s_axi_bvalid;
	endproperty
	a_b_answer: assert property (p_b_answer)
		else $error("write response late");
	property p_dio_data_mode;
		bus_out.dio_oe |-> !$past(bus_in.atn);
	endproperty
	a_dio_data_mode: assert property (p_dio_data_mode)
		else $error("data lines driven in command mode");
	property p_srq_low;
		bus_out.srq_oe |-> !bus_out.srq_o;
	endproperty
	a_srq_low: assert property (p_srq_low)
		else $error("srq driven high");
	property p_srq_led;
		inst.srq_led == bus_out.srq_oe;
	endproperty
	a_srq_led: assert property (p_srq_led)
		else $error("srq indicator differs from srq");
	property p_srq_release;
		s_poll_ack |-> ##3 !bus_out.srq_oe;
	endproperty
	a_srq_release: assert property (p_srq_release)
		else $error("srq kept after poll");
	property p_ifc_unaddr;
		bus_in.ifc |-> ##2 !bus_out.dio_oe;
	endproperty
	a_ifc_unaddr: assert property (p_ifc_unaddr)
		else $error("still talking after ifc");
	property p_ren_local;
		!bus_in.ren |-> ##2 !(inst.lockout || inst.remote_led);
	endproperty
	a_ren_local: assert property (p_ren_local)
		else $error("remote or lockout without ren");
	property p_sweep_cause;
		inst.sweep_start |-> ($past(bus_in.byte_stb) && $past(bus_in.atn))
			|| ($past(bus_in.byte_stb, 2) && $past(bus_in.atn, 2));
	endproperty
	a_sweep_cause: assert property (p_sweep_cause)
		else $error("sweep start without command");
endmodule : gdi_core_properties
`default_nettype wire

// ### tb/gdi_ctl_model.sv
/* gdi_ctl_model: behavioural bus controller facing gdi_core.
   assumes: shares aclk with the port, lines already synchronised. */
`timescale 1ns/1ps
`default_nettype none
module gdi_ctl_model (
	// clock
	input wire logic aclk,
	// bus lines
	output var gdi_pkg::gdi_bus_in_t bus_in,
	input wire gdi_pkg::gdi_bus_out_t bus_out
);
	initial bus_in = '0;
	task automatic lines(input logic atn, input logic ifc, input logic ren,
		input logic eoi);
		@(posedge aclk);
		bus_in.atn <= atn;
		bus_in.ifc <= ifc;
		bus_in.ren <= ren;
		bus_in.eoi <= eoi;
	endtask : lines
	// released data lines show the inverse
	task automatic send(input logic atn, input logic [7:0] b);
		@(posedge aclk);
		bus_in.atn <= atn;
		bus_in.data <= b;
		bus_in.byte_stb <= 1'b1;
		@(posedge aclk);
		bus_in.byte_stb <= 1'b0;
		bus_in.data <= ~b;
	endtask : send
	task automatic poll(output logic [7:0] sb, output logic ok);
		ok = 1'b0;
		repeat (20) begin
			@(posedge aclk);
			if (bus_out.dio_oe === 1'b1) begin
				ok = 1'b1;
				break;
			end
		end
		sb = bus_out.dio;
		bus_in.talk_ack <= 1'b1;
		@(posedge aclk);
		bus_in.talk_ack <= 1'b0;
	endtask : poll
endmodule : gdi_ctl_model
`default_nettype wire

// ### tb/gdi_device_interface_tb.sv
/* gdi_device_interface_tb: register and bus scenarios for gdi_core.
   assumes: gdi_ctl_model as controller, checker bound at the foot. */
`timescale 1ns/1ps
`default_nettype none
module gdi_device_interface_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	gdi_pkg::gdi_bus_in_t bus_in;
	gdi_pkg::gdi_bus_out_t bus_out;
	gdi_pkg::gdi_inst_t inst;
	int n_errors = 0, checked = 0, preset_n = 0, start_n = 0;
	always #4 aclk = ~aclk;
	gdi_core gdi_core_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus_in(bus_in),
		.bus_out(bus_out), .nv_addr_rd(5'h05), .nv_addr_we(),
		.nv_addr_wr(), .inst(inst));
	gdi_ctl_model gdi_ctl_model_i (.aclk(aclk), .bus_in(bus_in),
		.bus_out(bus_out));
	always @(posedge aclk) begin
		if (inst.preset === 1'b1) preset_n <= preset_n + 1;
		if (inst.sweep_start === 1'b1) start_n <= start_n + 1;
	end
	task automatic stop_test;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %0h seen %0h", what, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// the wait ends when bvalid is seen, or else on the watchdog
		forever begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		bready <= 1'b0;
		chk("bresp", {30'h0, gdi_pkg::RESP_OKAY}, {30'h0, bresp});
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		d = 32'hFFFFFFFF;
		r = 2'h3;
		forever begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				break;
			end
		end
		rready <= 1'b0;
	endtask : rd
	task automatic rc(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk($sformatf("reg %0h", a), e, d & m);
	endtask : rc
	task automatic cmd(input logic [6:0] b);
		gdi_ctl_model_i.send(1'b1, {1'b0, b});
	endtask : cmd
	task automatic ln(input logic atn, input logic ifc, input logic ren,
		input logic eoi);
		gdi_ctl_model_i.lines(atn, ifc, ren, eoi);
		repeat (3) @(posedge aclk);
	endtask : ln
	initial begin
		logic [7:0] sb;
		logic ok;
		logic [31:0] d;
		logic [1:0] r;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		ln(1, 0, 1, 0);
		rc(gdi_pkg::OFS_ADDR, 'h1F, 'h05);
		rd(8'h1C, d, r);
		chk("unmapped", gdi_pkg::RESP_SLVERR, r);
		wr(gdi_pkg::OFS_ADDR, 'h1F);
		rc(gdi_pkg::OFS_STAT, 'h200, 'h200);
		chk("listen_only", 1, inst.listen_only);
		wr(gdi_pkg::OFS_ADDR, 'h03);
		rc(gdi_pkg::OFS_ADDR, 'h1F, 'h03);
		wr(gdi_pkg::OFS_MASK, 'h1);
		wr(gdi_pkg::OFS_COND, 'h2);
		rc(gdi_pkg::OFS_STAT, 'hFF, 'h02);
		wr(gdi_pkg::OFS_COND, 'h3);
		rc(gdi_pkg::OFS_STAT, 'hFF, 'h43);
		chk("srq", 1, bus_out.srq_oe);
		cmd(gdi_pkg::CMD_SPE);
		cmd('h43);
		ln(0, 0, 1, 0);
		gdi_ctl_model_i.poll(sb, ok);
		chk("poll", 'h143, {ok, sb});
		repeat (4) @(posedge aclk);
		chk("srq", 0, bus_out.srq_oe);
		ln(1, 0, 1, 0);
		cmd(gdi_pkg::CMD_SPD);
		cmd(gdi_pkg::CMD_UNT);
		wr(gdi_pkg::OFS_COND, 'h3);
		rc(gdi_pkg::OFS_STAT, 'hFF, 'h00);
		wr(gdi_pkg::OFS_MASK, 'hF);
		wr(gdi_pkg::OFS_COND, 'h33);
		rc(gdi_pkg::OFS_STAT, 'hFF, 'hA0);
		wr(gdi_pkg::OFS_COND, 'h0);
		wr(gdi_pkg::OFS_ADDR, 'd40);
		rc(gdi_pkg::OFS_ADDR, 'h1F, 'h03);
		rc(gdi_pkg::OFS_ERR, 'hFF, 'h64);
		cmd('h23);
		rc(gdi_pkg::OFS_STAT, 'h3400, 'h1400);
		cmd(gdi_pkg::CMD_LLO);
		wr(gdi_pkg::OFS_CTRL, 'h4);
		cmd(gdi_pkg::CMD_GTL);
		rc(gdi_pkg::OFS_STAT, 'h3000, 'h3000);
		ln(1, 0, 0, 0);
		rc(gdi_pkg::OFS_STAT, 'h3000, 'h0);
		ln(1, 0, 1, 0);
		cmd('h23);
		wr(gdi_pkg::OFS_CTRL, 'h4);
		rc(gdi_pkg::OFS_STAT, 'h1000, 'h0);
		cmd('h23);
		cmd(gdi_pkg::CMD_GTL);
		rc(gdi_pkg::OFS_STAT, 'h1000, 'h0);
		gdi_ctl_model_i.send(1'b0, 8'h5A);
		rc(gdi_pkg::OFS_DATA, 'h1FF, 'h15A);
		cmd(gdi_pkg::CMD_UNL);
		gdi_ctl_model_i.send(1'b0, 8'hA5);
		cmd(gdi_pkg::CMD_SDC);
		rc(gdi_pkg::OFS_DATA, 'h1FF, 'h05A);
		cmd(gdi_pkg::CMD_DCL);
		rc(gdi_pkg::OFS_ERR, 'hFF, 'h0);
		cmd('h23);
		cmd(gdi_pkg::CMD_SDC);
		repeat (2) @(posedge aclk);
		chk("presets", 2, preset_n);
		wr(gdi_pkg::OFS_CTRL, 'h1);
		cmd(gdi_pkg::CMD_GET);
		wr(gdi_pkg::OFS_CTRL, 'h3);
		cmd(gdi_pkg::CMD_GET);
		repeat (3) @(posedge aclk);
		chk("sweeps", 1, start_n);
		cmd('h43);
		ln(1, 0, 1, 1);
		cmd('h05);
		cmd('h09);
		chk("dio_oe", 0, bus_out.dio_oe);
		rc(gdi_pkg::OFS_STAT, 'h0C00, 'h0800);
		ln(1, 1, 1, 0);
		ln(1, 0, 1, 0);
		rc(gdi_pkg::OFS_STAT, 'h0C00, 'h0);
		wr(gdi_pkg::OFS_CTRL, 'h8);
		rc(gdi_pkg::OFS_ADDR, 'h1F, 'h11);
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		stop_test();
	end
endmodule : gdi_device_interface_tb
bind gdi_core gdi_core_properties gdi_core_properties_i (.aclk(aclk),
	.aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.bus_in(bus_in), .bus_out(bus_out), .inst(inst));
`default_nettype wire
